// ### hw/slb_pkg.sv
package slb_pkg;
  // ==========================================================
  // Link framing
  localparam int unsigned PAY_W       = 35;
  localparam int unsigned BC_W        = 8;
  localparam int unsigned BC_REQ_BIT  = 0;
  localparam logic [7:0]  BC_CHK_KEY  = 8'h5a;
  localparam logic [34:0] SCR_SEED    = 35'h000000001;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned OSC_MHZ     = 33;
  localparam int unsigned HALF_OSC_NS = 500 / OSC_MHZ;
  // Half pixel period, rounded down, never below one cycle
  localparam int unsigned HALF_PCLK_CYC = (HALF_OSC_NS / CLK_NS) > 0 ?
                                          (HALF_OSC_NS / CLK_NS) : 1;
  localparam int unsigned LOCK_FRAMES = 8;
  // ==========================================================
  // Counters, straps and pass level
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned EQ_W        = 4;
  localparam logic [3:0]  STRAP_BIST  = 4'h1;
  localparam logic        PASS_RST    = 1'b1;
  // ==========================================================
  // Register map: index, byte address is four times the index
  localparam logic [7:0]  CFG_IDX     = 8'h24;
  localparam logic [7:0]  STAT_IDX    = 8'h25;
  localparam logic [9:0]  CFG_ADDR    = {CFG_IDX, 2'b00};
  localparam logic [9:0]  STAT_ADDR   = {STAT_IDX, 2'b00};
  localparam int unsigned CFG_EN_BIT    = 0;
  localparam int unsigned CFG_OSC_BIT   = 1;
  localparam int unsigned CFG_EQRST_BIT = 2;
  localparam int unsigned STAT_SEEN_BIT = 8;
  localparam int unsigned STAT_LOCK_BIT = 9;
  localparam int unsigned STAT_ACT_BIT  = 10;

  // Scrambler step, x^35 + x^2 + 1
  function automatic logic [34:0] scr_next(input logic [34:0] s);
    return {s[33:0], s[34] ^ s[1]};
  endfunction

  // Back-channel frame check field
  function automatic logic [7:0] bc_check(input logic [7:0] d);
    return {d[3:0], d[7:4]} ^ BC_CHK_KEY;
  endfunction
endpackage

// ### hw/slb_link_if.sv
`timescale 1ns/1ps
interface slb_link_if;
  // Back channel, deserializer to serializer
  logic                      bc_valid;
  logic [slb_pkg::BC_W-1:0]  bc_data;
  logic [slb_pkg::BC_W-1:0]  bc_chk;
  // Forward channel, serializer to deserializer
  logic                      fc_active;
  logic                      fc_valid;
  logic                      fc_bist;
  logic [slb_pkg::PAY_W-1:0] fc_payload;

  modport des (
    output bc_valid, bc_data, bc_chk,
    input  fc_active, fc_valid, fc_bist, fc_payload
  );
  modport ser (
    input  bc_valid, bc_data, bc_chk,
    output fc_active, fc_valid, fc_bist, fc_payload
  );
endinterface

// ### hw/slb_des_end.sv
`timescale 1ns/1ps
module slb_des_end (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  slb_link_if.des          link,
  input  wire logic        i_self_test_enable_pin,
  input  wire logic        i_self_test_clock_select_pin,
  input  wire logic        i_pclk_present,
  input  wire logic [3:0]  i_general_io_strap,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [9:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_pass,
  output logic             o_lock,
  output logic             o_bist_active,
  output logic             o_internal_oscillator_sel,
  output logic [slb_pkg::EQ_W-1:0] o_adaptive_equalizer_step
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_CHECK = 2'b10
  } slb_state_type;
  localparam int unsigned PW = 4;
  localparam logic [PW-1:0] HALF = PW'(slb_pkg::HALF_PCLK_CYC);
  localparam logic [3:0] LOCK_N = 4'(slb_pkg::LOCK_FRAMES);

  // ==========================================================
  // Pin synchronisers
  logic [6:0] s1_q, s2_q;
  // Pins are asynchronous; only the second stage is read
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
    end else begin
      s1_q <= {i_self_test_clock_select_pin, i_self_test_enable_pin,
               i_general_io_strap, i_pclk_present};
      s2_q <= s1_q;
    end
  end

  logic       pclk_ok, en_pin, sel_pin;
  logic [3:0] strap;
  assign pclk_ok = s2_q[0];
  assign strap   = s2_q[4:1];
  assign en_pin  = s2_q[5];
  assign sel_pin = s2_q[6];
  // ==========================================================
  // Register bus
  logic        ack_q, ack_d, cfg_en_q, cfg_en_d, cfg_osc_q, cfg_osc_d;
  logic        eq_rst, seen_q, lock_q;
  logic [31:0] rdat_q, rdat_d;
  logic [slb_pkg::CNT_W-1:0] cnt_q;
  slb_state_type st_q;
  // Answer one cycle after the strobe; unmapped reads give zero
  always_comb begin
    ack_d     = i_wb_cyc & i_wb_stb & ~ack_q;
    rdat_d    = rdat_q;
    cfg_en_d  = cfg_en_q;
    cfg_osc_d = cfg_osc_q;
    eq_rst    = 1'b0;
    if (ack_d) begin
      rdat_d = 32'h00000000;
      if (i_wb_adr == slb_pkg::CFG_ADDR) begin
        rdat_d[slb_pkg::CFG_EN_BIT]  = cfg_en_q;
        rdat_d[slb_pkg::CFG_OSC_BIT] = cfg_osc_q;
        if (i_wb_we && i_wb_sel[0]) begin
          cfg_en_d  = i_wb_dat[slb_pkg::CFG_EN_BIT];
          cfg_osc_d = i_wb_dat[slb_pkg::CFG_OSC_BIT];
          eq_rst    = i_wb_dat[slb_pkg::CFG_EQRST_BIT];
        end
      end else if (i_wb_adr == slb_pkg::STAT_ADDR) begin
        rdat_d[slb_pkg::CNT_W-1:0]     = cnt_q;
        rdat_d[slb_pkg::STAT_SEEN_BIT] = seen_q;
        rdat_d[slb_pkg::STAT_LOCK_BIT] = lock_q;
        rdat_d[slb_pkg::STAT_ACT_BIT]  = (st_q != ST_IDLE);
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q     <= 1'b0;
      rdat_q    <= 32'h00000000;
      cfg_en_q  <= 1'b0;
      cfg_osc_q <= 1'b0;
    end else begin
      ack_q     <= ack_d;
      rdat_q    <= rdat_d;
      cfg_en_q  <= cfg_en_d;
      cfg_osc_q <= cfg_osc_d;
    end
  end
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  // ==========================================================
  // Enable, clock choice and back channel
  logic bist_en;
  // Wrong straps keep the test off rather than run it half set up
  assign bist_en = (en_pin | cfg_en_q) & (strap == slb_pkg::STRAP_BIST);
  // Oscillator only matters with no pixel clock present
  assign o_internal_oscillator_sel = ~pclk_ok & (sel_pin | cfg_osc_q);
  logic                     bcv_q;
  logic [slb_pkg::BC_W-1:0] bcd_q, bcd_d;
  // Enable bit rides in every back-channel frame
  always_comb begin
    bcd_d = '0;
    bcd_d[slb_pkg::BC_REQ_BIT] = bist_en;
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bcv_q <= 1'b0;
      bcd_q <= '0;
    end else begin
      bcv_q <= 1'b1;
      bcd_q <= bcd_d;
    end
  end
  assign link.bc_valid = bcv_q;
  assign link.bc_data  = bcd_q;
  assign link.bc_chk   = slb_pkg::bc_check(bcd_q);

  // ==========================================================
  // Lock and descrambler
  logic [3:0]                lcnt_q, lcnt_d;
  logic                      lock_d;
  logic [slb_pkg::PAY_W-1:0] ref_q,  ref_d;
  logic                      ferr;
  // Lock after a run of frames; drops at once with the link
  always_comb begin
    lcnt_d = lcnt_q;
    ref_d  = ref_q;
    if (!link.fc_active) begin
      lcnt_d = 4'h0;
    end else if (link.fc_valid && lcnt_q != LOCK_N) begin
      lcnt_d = lcnt_q + 4'h1;
    end
    lock_d = link.fc_active & (lcnt_d == LOCK_N);
    // Reference tracks the sender's scrambler frame by frame
    if (!link.fc_bist) begin
      ref_d = slb_pkg::SCR_SEED;
    end else if (link.fc_valid) begin
      ref_d = slb_pkg::scr_next(ref_q);
    end
  end
  // Whole 35-bit payload compared against descrambled zeros
  assign ferr = link.fc_valid & link.fc_bist & (link.fc_payload != ref_q);
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lcnt_q <= 4'h0;
      lock_q <= 1'b0;
      ref_q  <= slb_pkg::SCR_SEED;
    end else begin
      lcnt_q <= lcnt_d;
      lock_q <= lock_d;
      ref_q  <= ref_d;
    end
  end

  // ==========================================================
  // Test sequencer and pass output
  slb_state_type             st_d;
  logic [slb_pkg::CNT_W-1:0] cnt_d;
  logic                      seen_d;
  logic [PW-1:0]             pul_q, pul_d;
  logic                      pass_q, pass_d;
  logic [slb_pkg::EQ_W-1:0]  eq_q, eq_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    seen_d = seen_q;
    pul_d  = pul_q;
    pass_d = pass_q;
    eq_d   = eq_q;
    case (st_q)
      ST_IDLE: begin
        if (bist_en) begin
          st_d   = ST_WAIT;
          cnt_d  = '0;
          seen_d = 1'b0;
          pass_d = 1'b0;
        end
      end
      ST_WAIT: begin
        if (!bist_en) begin
          st_d   = ST_IDLE;
          pass_d = ~seen_q;
          eq_d   = eq_q + 1'b1;
        end else if (lock_q && link.fc_bist) begin
          st_d   = ST_CHECK;
          pass_d = 1'b1;
          pul_d  = '0;
        end
      end
      ST_CHECK: begin
        if (!bist_en) begin
          st_d   = ST_IDLE;
          pass_d = ~(seen_q | ferr);
          eq_d   = eq_q + 1'b1;
        end else if (!lock_q) begin
          st_d   = ST_WAIT;
          cnt_d  = '0;
          seen_d = 1'b0;
          pass_d = 1'b0;
        end else if (ferr) begin
          // Count saturates so a long run never wraps to clean
          if (cnt_q != '1) begin
            cnt_d = cnt_q + 1'b1;
          end
          seen_d = 1'b1;
          pul_d  = HALF;
          pass_d = 1'b0;
        end else if (pul_q != '0) begin
          pul_d  = pul_q - 1'b1;
          pass_d = (pul_q == {{(PW-1){1'b0}}, 1'b1});
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // Software reset of the equalizer wins over the step
    if (eq_rst) begin
      eq_d = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q   <= ST_IDLE;
      cnt_q  <= '0;
      seen_q <= 1'b0;
      pul_q  <= '0;
      pass_q <= slb_pkg::PASS_RST;
      eq_q   <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
      pul_q  <= pul_d;
      pass_q <= pass_d;
      eq_q   <= eq_d;
    end
  end

  assign o_pass                    = pass_q;
  assign o_lock                    = lock_q;
  assign o_bist_active             = (st_q != ST_IDLE);
  assign o_adaptive_equalizer_step = eq_q;
endmodule // slb_des_end

// ### hw/slb_ser_end.sv
`timescale 1ns/1ps
module slb_ser_end (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_reset_n,
  slb_link_if.ser                        link,
  input  wire logic                      i_power_down,
  input  wire logic                      i_tx_valid,
  input  wire logic [slb_pkg::PAY_W-1:0] i_tx_payload,
  input  wire logic                      i_inject_err,
  output logic                           o_awake,
  output logic                           o_bist_active,
  output logic [slb_pkg::CNT_W-1:0]      o_bc_crc_errs
);
  typedef enum logic [1:0] {
    SS_SLEEP  = 2'b00,
    SS_NORMAL = 2'b01,
    SS_BIST   = 2'b10
  } slb_sstate_type;

  // ==========================================================
  // Back-channel frame check
  logic bc_good;
  logic bc_bad;
  logic bc_req;
  assign bc_good = link.bc_valid & (link.bc_chk == slb_pkg::bc_check(link.bc_data));
  assign bc_bad  = link.bc_valid & ~bc_good;
  assign bc_req  = bc_good & link.bc_data[slb_pkg::BC_REQ_BIT];

  // ==========================================================
  // Mode sequencer and forward frames
  slb_sstate_type            st_q,   st_d;
  logic [slb_pkg::CNT_W-1:0] crc_q,  crc_d;
  logic [slb_pkg::PAY_W-1:0] scr_q,  scr_d;
  logic                      act_q,  act_d;
  logic                      fv_q,   fv_d;
  logic                      fb_q,   fb_d;
  logic [slb_pkg::PAY_W-1:0] pay_q,  pay_d;

  always_comb begin
    st_d  = st_q;
    crc_d = crc_q;
    case (st_q)
      SS_SLEEP: begin
        if (bc_req) begin
          st_d  = SS_BIST;
          crc_d = '0;
        end else if (!i_power_down) begin
          st_d = SS_NORMAL;
        end
      end
      SS_NORMAL: begin
        if (bc_req) begin
          st_d  = SS_BIST;
          crc_d = '0;
        end else if (i_power_down) begin
          st_d = SS_SLEEP;
        end
      end
      SS_BIST: begin
        // Only a frame that checks good may end the test
        if (bc_good && !bc_req) begin
          st_d = i_power_down ? SS_SLEEP : SS_NORMAL;
        end else if (bc_bad && crc_q != '1) begin
          crc_d = crc_q + 1'b1;
        end
      end
      default: begin
        st_d = SS_SLEEP;
      end
    endcase
    // Scrambled zeros: payload is the scrambler state itself
    scr_d = (st_q == SS_BIST) ? slb_pkg::scr_next(scr_q) : slb_pkg::SCR_SEED;
    act_d = (st_q != SS_SLEEP);
    fb_d  = (st_q == SS_BIST);
    fv_d  = fb_d | ((st_q == SS_NORMAL) & i_tx_valid);
    pay_d = fb_d ? (scr_q ^ slb_pkg::PAY_W'(i_inject_err)) : i_tx_payload;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q  <= SS_SLEEP;
      crc_q <= '0;
      scr_q <= slb_pkg::SCR_SEED;
      act_q <= 1'b0;
      fv_q  <= 1'b0;
      fb_q  <= 1'b0;
      pay_q <= '0;
    end else begin
      st_q  <= st_d;
      crc_q <= crc_d;
      scr_q <= scr_d;
      act_q <= act_d;
      fv_q  <= fv_d;
      fb_q  <= fb_d;
      pay_q <= pay_d;
    end
  end

  assign link.fc_active  = act_q;
  assign link.fc_valid   = fv_q;
  assign link.fc_bist    = fb_q;
  assign link.fc_payload = pay_q;
  assign o_awake         = (st_q != SS_SLEEP);
  assign o_bist_active   = (st_q == SS_BIST);
  assign o_bc_crc_errs   = crc_q;
endmodule // slb_ser_end

// ### verification/slb_link_monitor.sv
`timescale 1ns/1ps
// ==========================================
// Watcher on the link between both ends
module slb_link_monitor (
  input wire logic                      i_ref_clk,
  input wire logic                      i_reset_n,
  input wire logic                      bc_valid,
  input wire logic [slb_pkg::BC_W-1:0]  bc_data,
  input wire logic [slb_pkg::BC_W-1:0]  bc_chk,
  input wire logic                      fc_active,
  input wire logic                      fc_valid,
  input wire logic                      fc_bist,
  input wire logic [slb_pkg::PAY_W-1:0] fc_payload
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Edges of the test request
  sequence s_req_rise;
    $rose(bc_data[slb_pkg::BC_REQ_BIT]);
  endsequence
  sequence s_req_fall;
    $fell(bc_data[slb_pkg::BC_REQ_BIT]);
  endsequence

  // Back channel framing
  chk_bc_check_field: assert property (bc_valid |->
    bc_chk == ({bc_data[3:0], bc_data[7:4]} ^ slb_pkg::BC_CHK_KEY))
    else $error("back channel check field wrong");
  chk_bc_frames_run: assert property (bc_valid |=> bc_valid)
    else $error("back channel frames stopped");
  // Remote test mode follows the request, wake included
  chk_ser_enters_test: assert property (s_req_rise |-> ##[1:40] fc_bist)
    else $error("remote did not enter test");
  chk_ser_leaves_test: assert property (s_req_fall |-> ##[1:3] !fc_bist)
    else $error("remote did not leave test");
  chk_idle_no_test: assert property ((!bc_data[slb_pkg::BC_REQ_BIT]) [*3] |-> !fc_bist)
    else $error("test frames without request");
  chk_test_requested: assert property ($rose(fc_bist) |-> $past(bc_data[0], 2))
    else $error("test began unrequested");
  chk_test_at_speed: assert property (fc_bist |-> fc_valid && fc_active)
    else $error("test frame gap");
  // Bit 0 skipped: an injected fault flips only that bit
  chk_scramble_step: assert property (fc_bist && $past(fc_bist) |->
    fc_payload[34:2] == $past(fc_payload[33:1]))
    else $error("scrambled stream not stepping");
endmodule // slb_link_monitor

// ### verification/tb_serial_link_bist_checker.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the self-test pair
module tb_serial_link_bist_checker;
  logic        clk, rst_n, en_pin, cs_pin, pclk_ok, pdown, tx_v, inj, cnt_on;
  logic        cyc, stb, we, ack, pass, pass_q, lock, act, osc, s_awake, s_act;
  logic [3:0]  strap, eq, sel, wsel;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [34:0] tx_pay;
  logic [7:0]  crc;
  int          n_fail, checks, seed, n_inj, n_low, n_edge, gap;
  slb_link_if  link ();

  slb_des_end i_slb_des_end (.i_ref_clk(clk), .i_reset_n(rst_n), .link(link.des),
    .i_self_test_enable_pin(en_pin), .i_self_test_clock_select_pin(cs_pin),
    .i_pclk_present(pclk_ok), .i_general_io_strap(strap), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_pass(pass), .o_lock(lock), .o_bist_active(act),
    .o_internal_oscillator_sel(osc), .o_adaptive_equalizer_step(eq));
  slb_ser_end i_slb_ser_end (.i_ref_clk(clk), .i_reset_n(rst_n), .link(link.ser),
    .i_power_down(pdown), .i_tx_valid(tx_v), .i_tx_payload(tx_pay), .i_inject_err(inj),
    .o_awake(s_awake), .o_bist_active(s_act), .o_bc_crc_errs(crc));
  slb_link_monitor i_slb_link_monitor (.i_ref_clk(clk), .i_reset_n(rst_n),
    .bc_valid(link.bc_valid), .bc_data(link.bc_data), .bc_chk(link.bc_chk),
    .fc_active(link.fc_active), .fc_valid(link.fc_valid), .fc_bist(link.fc_bist),
    .fc_payload(link.fc_payload));

  // Clock, 10 ns
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Expected error count; the counter stops at its top
  function automatic logic [7:0] exp_count(input int n);
    return (n > 255) ? 8'hff : 8'(n);
  endfunction

  // Expected held result: clean only when no frame was bad
  function automatic logic exp_pass(input int n);
    return (n == 0);
  endfunction

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Classic single cycle; no answer time is assumed
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (ack === 1'h1) break;
    end
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (k == 50) begin
      n_fail++;
      conclude();
    end
  endtask

  // Bounded wait for a level
  task automatic wait_for(ref logic s, input logic v);
    int k;
    for (k = 0; k < 300 && s !== v; k++) @(posedge clk);
    if (s !== v) begin
      n_fail++;
      conclude();
    end
  endtask

  // Random normal-mode traffic, ignored during test
  always @(posedge clk) begin
    tx_v <= 1'($random(seed));
    tx_pay <= 35'({$random(seed), $random(seed)});
  end

  // Low cycles and falling edges of pass
  always @(posedge clk) begin
    pass_q <= pass;
    if (cnt_on && pass === 1'h0) n_low++;
    if (cnt_on && pass === 1'h0 && pass_q === 1'h1) n_edge++;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 32'h177e4cbd;
    {cyc, stb, we, en_pin, cs_pin, inj, cnt_on, tx_v} = '0;
    {adr, wdat, tx_pay} = '0;
    strap = 4'h3;
    {sel, wsel} = 8'hff;
    pclk_ok = 1'h1;
    pdown = 1'h1;
    rst_n = 1'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    // Wrong straps keep the test off; remote stays asleep
    en_pin <= 1'h1;
    repeat (20) @(posedge clk);
    check(pass, 1'h1);
    check(act, 1'h0);
    check(link.bc_data[0], 1'h0);
    check(s_awake, 1'h0);
    wb(1'h0, 10'h3fc, 32'h0);
    check(rd, 32'h0);
    $display("test straps done");
    // Good straps: remote wakes, lock, then checking
    strap <= slb_pkg::STRAP_BIST;
    wait_for(s_act, 1'h1);
    check(s_awake, 1'h1);
    pdown <= 1'h0;
    wait_for(lock, 1'h1);
    repeat (3) @(posedge clk);
    check(pass, 1'h1);
    check(act, 1'h1);
    // Spaced faults so each gives its own pulse
    {n_inj, n_low, n_edge, gap} = '0;
    cnt_on <= 1'h1;
    repeat (400) begin
      @(posedge clk);
      gap++;
      if (gap > 3 && ($random(seed) & 7) == 0) begin
        inj <= 1'h1;
        n_inj++;
        gap = 0;
      end else begin
        inj <= 1'h0;
      end
    end
    repeat (6) @(posedge clk);
    cnt_on <= 1'h0;
    check(n_edge, n_inj);
    check(n_low, n_inj * slb_pkg::HALF_PCLK_CYC);
    wb(1'h0, slb_pkg::STAT_ADDR, 32'h0);
    check(rd[7:0], exp_count(n_inj));
    check(rd[10:8], {2'h3, ~exp_pass(n_inj)});
    // Pin low ends the test; result held
    en_pin <= 1'h0;
    wait_for(act, 1'h0);
    repeat (20) @(posedge clk);
    check(pass, exp_pass(n_inj));
    check(eq, 4'h1);
    check(s_act, 1'h0);
    check(crc, 8'h0);
    $display("test pin run done");
    // Register enable with oscillator choice
    pclk_ok <= 1'h0;
    wb(1'h1, slb_pkg::CFG_ADDR, 32'h3);
    repeat (4) @(posedge clk);
    check(osc, 1'h1);
    pclk_ok <= 1'h1;
    repeat (4) @(posedge clk);
    check(osc, 1'h0);
    wait_for(act, 1'h1);
    repeat (60) @(posedge clk);
    check(pass, 1'h1);
    wb(1'h1, slb_pkg::CFG_ADDR, 32'h0);
    wait_for(act, 1'h0);
    repeat (4) @(posedge clk);
    check(pass, 1'h1);
    check(eq, 4'h2);
    // Pin path for the oscillator, then equalizer reset
    cs_pin <= 1'h1;
    pclk_ok <= 1'h0;
    repeat (4) @(posedge clk);
    check(osc, 1'h1);
    wb(1'h1, slb_pkg::CFG_ADDR, 32'h4);
    repeat (2) @(posedge clk);
    check(eq, 4'h0);
    wb(1'h0, slb_pkg::CFG_ADDR, 32'h0);
    check(rd, 32'h0);
    // Write without the low byte lane must not start a test
    wsel = 4'he;
    wb(1'h1, slb_pkg::CFG_ADDR, 32'h1);
    wsel = 4'hf;
    wb(1'h0, slb_pkg::CFG_ADDR, 32'h0);
    check(rd, 32'h0);
    $display("test register run done");
    conclude();
  end
endmodule // tb_serial_link_bist_checker
